// ===== mfs_pkg.sv
// mfs_pkg: constants, types and helpers for the float register slave
package mfs_pkg;
  // function codes and exception answers
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;
  // register index mapping and count limits
  localparam logic [15:0] REG_BASE = 16'h0100;
  localparam logic [15:0] WRITE_REG = 16'h01aa;
  localparam logic [15:0] READ_MIN_REGS = 16'h0002;
  localparam logic [15:0] READ_MAX_REGS = 16'h007c;
  localparam logic [15:0] WRITE_REGS = 16'h0002;
  localparam logic [7:0] WRITE_BYTES = 8'h04;
  // size of the parameter list behind the slave, a plain default
  localparam logic [8:0] PARAM_COUNT = 9'h040;
  // request body lengths without address and checksum
  localparam logic [7:0] READ_BODY = 8'h05;
  localparam logic [7:0] WRITE_BODY = 8'h0a;
  localparam logic [7:0] SERIAL_EXTRA = 8'h03;
  localparam logic [7:0] SERIAL_MIN = 8'h04;
  // stored request bytes; longer frames are counted, not kept
  localparam logic [7:0] BUF_DEPTH = 8'h0c;
  localparam logic [2:0] ECHO_LEN = 3'h6;
  // written float values that pick the calibration state
  localparam logic [31:0] VAL_MEASURE = 32'h00000000;
  localparam logic [31:0] VAL_CYCLE = 32'h3f800000;
  localparam logic [31:0] VAL_ZERO = 32'h40000000;
  localparam logic [31:0] VAL_SPAN = 32'h40400000;
  // checksum
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  typedef enum logic [1:0] {
    MFS_MEASURE = 2'b00,
    MFS_CYCLE = 2'b01,
    MFS_ZERO = 2'b10,
    MFS_SPAN = 2'b11
  } mfs_cal_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_HDR = 3'b010,
    ST_DATA = 3'b011,
    ST_CRC_HI = 3'b100,
    ST_CRC_LO = 3'b101
  } mfs_state_type;

  // one byte through the reflected checksum polynomial
  function automatic logic [15:0] mfs_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// ===== mfs_slave.sv
// mfs_slave: request parser, checker and responder for the float register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - only function 3 (read) and 16 (write) are served; others give exception 1
// - serial frames start with the configured slave address; tcp frames have none
// - serial frames end with the crc, high byte first; tcp frames have none
// - start register is list number times two plus 256, high byte first
// - read returns consecutive parameters from the start register
// - endian input places the float's top byte rightmost (big) or leftmost (little)
// - read answer: address, 3, register count, float bytes, crc
// - only write target is register 426 (0x01aa) with count 2, setting calibration state
// - written value picks measure, cycle, zero or span
// - good write is answered by echoing the first six request bytes
// - error answer carries function plus 128, one exception byte and crc
// - exception 1 function, 2 address, 3 value, 4 slave failure
module mfs_slave
  import mfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tcp_mode_in,
  input wire logic [7:0] serial_id_in,
  input wire logic big_endian_in,
  input wire logic param_fail_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_end_in,
  output logic rx_ready_out,
  output logic [7:0] param_index_out,
  input wire logic [31:0] param_data_in,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  output mfs_cal_type cal_mode_out,
  output logic cal_update_out
);

  // pick byte j of a float in wire order
  function automatic logic [7:0] pick_byte(input logic [31:0] f, input logic [1:0] j, input logic big);
    logic [1:0] k;
    k = big ? j : 2'(2'd3 - j);
    return f[8 * k +: 8];
  endfunction

  mfs_state_type state;
  logic [7:0] buf_mem [0:11];
  logic [7:0] rx_len;
  logic [7:0] last0;
  logic [7:0] last1;
  logic [15:0] crc_run;
  logic [15:0] crc_d1;
  logic [15:0] crc_d2;
  logic [15:0] tx_crc;
  logic [7:0] resp [0:5];
  logic [2:0] hlen;
  logic [2:0] hk;
  logic [1:0] bk;
  logic [6:0] vals_left;
  logic read_go;
  logic can_load;
  // decision terms
  logic [3:0] base;
  logic [7:0] fc;
  logic [15:0] start;
  logic [15:0] cnt;
  logic [31:0] wval;
  logic [15:0] first_idx;
  logic [7:0] body_len;
  logic next_drop;
  logic next_read;
  logic next_write;
  logic [7:0] next_exc;
  mfs_cal_type next_mode;

  assign rx_ready_out = (state == ST_IDLE);
  assign can_load = !tx_valid_out || tx_ready_in;

  ////////////////////////////////////////////////////////////////////////////
  // receive side
  // request bytes; storage needs no reset, length gates every use
  always_ff @(posedge clk_in) begin
    if (rx_ready_out && rx_valid_in && rx_len < BUF_DEPTH) begin
      buf_mem[rx_len[3:0]] <= rx_data_in;
    end
  end

  // length, last two bytes and a checksum lagging two bytes behind
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_len <= 8'h00;
      last0 <= 8'h00;
      last1 <= 8'h00;
      crc_run <= CRC_INIT;
      crc_d1 <= CRC_INIT;
      crc_d2 <= CRC_INIT;
    end else if (state == ST_CHECK) begin
      rx_len <= 8'h00;
      crc_run <= CRC_INIT;
      crc_d1 <= CRC_INIT;
      crc_d2 <= CRC_INIT;
    end else if (rx_ready_out && rx_valid_in) begin
      rx_len <= rx_len + {7'h00, rx_len != 8'hff}; // saturates, long frames stay long
      last1 <= last0;
      last0 <= rx_data_in;
      crc_d2 <= crc_d1;
      crc_d1 <= crc_run;
      crc_run <= mfs_crc_byte(crc_run, rx_data_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request check
  // field offsets shift by one when the address byte is present
  always_comb begin
    base = tcp_mode_in ? 4'h0 : 4'h1;
    fc = buf_mem[base];
    start = {buf_mem[base + 4'h1], buf_mem[base + 4'h2]};
    cnt = {buf_mem[base + 4'h3], buf_mem[base + 4'h4]};
    if (big_endian_in) begin
      wval = {buf_mem[base + 4'h9], buf_mem[base + 4'h8], buf_mem[base + 4'h7], buf_mem[base + 4'h6]};
    end else begin
      wval = {buf_mem[base + 4'h6], buf_mem[base + 4'h7], buf_mem[base + 4'h8], buf_mem[base + 4'h9]};
    end
    first_idx = (start - REG_BASE) >> 1;
    body_len = tcp_mode_in ? rx_len : rx_len - SERIAL_EXTRA;
    // silent drop: checksum is compared high byte first
    next_drop = !tcp_mode_in && (rx_len < SERIAL_MIN || buf_mem[0] != serial_id_in
                || crc_d2 != {last1, last0});
    next_read = 1'b0;
    next_write = 1'b0;
    next_exc = 8'h00;
    next_mode = MFS_MEASURE;
    case (wval)
      VAL_MEASURE: next_mode = MFS_MEASURE;
      VAL_CYCLE: next_mode = MFS_CYCLE;
      VAL_ZERO: next_mode = MFS_ZERO;
      VAL_SPAN: next_mode = MFS_SPAN;
      default: next_mode = MFS_MEASURE;
    endcase
    if (fc == FC_READ) begin
      if (body_len != READ_BODY || cnt[0] || cnt < READ_MIN_REGS || cnt > READ_MAX_REGS) begin
        next_exc = EXC_VALUE;
      end else if (start < REG_BASE || start[0]
                   || first_idx + {1'b0, cnt[15:1]} > {7'h00, PARAM_COUNT}) begin
        next_exc = EXC_ADDR;
      end else if (param_fail_in) begin
        next_exc = EXC_FAIL;
      end else begin
        next_read = 1'b1;
      end
    end else if (fc == FC_WRITE) begin
      if (start != WRITE_REG) begin
        next_exc = EXC_ADDR;
      end else if (body_len != WRITE_BODY || cnt != WRITE_REGS || buf_mem[base + 4'h5] != WRITE_BYTES) begin
        next_exc = EXC_VALUE;
      end else if (wval != VAL_MEASURE && wval != VAL_CYCLE && wval != VAL_ZERO && wval != VAL_SPAN) begin
        next_exc = EXC_VALUE;
      end else begin
        next_write = 1'b1;
      end
    end else begin
      next_exc = EXC_FUNC;
    end
  end

  // calibration state, changed only by an accepted write
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_mode_out <= MFS_MEASURE;
      cal_update_out <= 1'b0;
    end else begin
      cal_update_out <= 1'b0;
      if (state == ST_CHECK && !next_drop && next_write) begin
        cal_mode_out <= next_mode;
        cal_update_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer sequencer; one byte loads whenever the output slot is free
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      tx_data_out <= 8'h00;
      tx_valid_out <= 1'b0;
      tx_last_out <= 1'b0;
      tx_crc <= CRC_INIT;
      hlen <= 3'h0;
      hk <= 3'h0;
      bk <= 2'h0;
      vals_left <= 7'h00;
      read_go <= 1'b0;
      param_index_out <= 8'h00;
      for (int i = 0; i < 6; i++) begin
        resp[i] <= 8'h00;
      end
    end else begin
      if (tx_valid_out && tx_ready_in) begin
        tx_valid_out <= 1'b0;
        tx_last_out <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (rx_end_in) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          hk <= 3'h0;
          bk <= 2'h0;
          tx_crc <= CRC_INIT;
          read_go <= next_read;
          param_index_out <= first_idx[7:0];
          vals_left <= cnt[7:1];
          resp[0] <= buf_mem[0];
          resp[5] <= buf_mem[5];
          if (next_drop) begin
            state <= ST_IDLE;
          end else if (next_write) begin
            // echo of the leading request bytes as received
            for (int i = 1; i < 5; i++) begin
              resp[i] <= buf_mem[i];
            end
            hlen <= ECHO_LEN;
            state <= ST_HDR;
          end else if (next_read) begin
            resp[base[2:0]] <= FC_READ;
            resp[base[2:0] + 3'h1] <= cnt[15:8];
            resp[base[2:0] + 3'h2] <= cnt[7:0];
            hlen <= base[2:0] + 3'h3;
            state <= ST_HDR;
          end else begin
            resp[base[2:0]] <= fc | EXC_FLAG;
            resp[base[2:0] + 3'h1] <= next_exc;
            hlen <= base[2:0] + 3'h2;
            state <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (can_load) begin
            tx_data_out <= resp[hk];
            tx_valid_out <= 1'b1;
            tx_crc <= mfs_crc_byte(tx_crc, resp[hk]);
            hk <= hk + 3'h1;
            if (hk == hlen - 3'h1) begin
              if (read_go) begin
                state <= ST_DATA;
              end else if (tcp_mode_in) begin
                tx_last_out <= 1'b1;
                state <= ST_IDLE;
              end else begin
                state <= ST_CRC_HI;
              end
            end
          end
        end
        ST_DATA: begin
          if (can_load) begin
            // parameter value is read straight from the index output
            tx_data_out <= pick_byte(param_data_in, bk, big_endian_in);
            tx_valid_out <= 1'b1;
            tx_crc <= mfs_crc_byte(tx_crc, pick_byte(param_data_in, bk, big_endian_in));
            bk <= bk + 2'h1;
            if (bk == 2'h3) begin
              param_index_out <= param_index_out + 8'h01;
              vals_left <= vals_left - 7'h01;
              if (vals_left == 7'h01) begin
                tx_last_out <= tcp_mode_in;
                state <= tcp_mode_in ? ST_IDLE : ST_CRC_HI;
              end
            end
          end
        end
        ST_CRC_HI: begin
          if (can_load) begin
            tx_data_out <= tx_crc[15:8];
            tx_valid_out <= 1'b1;
            state <= ST_CRC_LO;
          end
        end
        ST_CRC_LO: begin
          if (can_load) begin
            tx_data_out <= tx_crc[7:0];
            tx_valid_out <= 1'b1;
            tx_last_out <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_tx_hold_stall: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("answer byte changed while stalled");
  a_ignore_bad_frame: assert property (state == ST_CHECK && next_drop |=> state == ST_IDLE ##1 !tx_valid_out)
    else $error("dropped frame produced output");
  a_exc_no_action: assert property (state == ST_CHECK && !next_write |=> !cal_update_out)
    else $error("calibration changed by a refused request");
  a_exc_fc_flag: assert property (state == ST_CHECK && !next_drop && next_exc != 8'h00
                                  |=> resp[base[2:0]] == ($past(fc) | 8'h80))
    else $error("exception function code wrong");
  a_bad_fc_code: assert property (state == ST_CHECK && fc != 8'h03 && fc != 8'h10 |-> next_exc == 8'h01)
    else $error("unsupported function not refused with code 1");
  a_write_target: assert property (state == ST_CHECK && next_write |-> start == 16'h01aa && cnt == 16'h0002)
    else $error("write accepted at wrong register or count");
  a_read_count: assert property (state == ST_CHECK && next_read
                                 |-> !cnt[0] && cnt >= 16'h0002 && cnt <= 16'h007c)
    else $error("read accepted with illegal count");
  a_cal_span_val: assert property (state == ST_CHECK && !next_drop && next_write && wval == VAL_SPAN
                                   |=> cal_mode_out == MFS_SPAN)
    else $error("span value did not select span");
  a_serial_crc_tail: assert property ($rose(tx_last_out) && tx_valid_out && !tcp_mode_in
                                      |-> tx_data_out == $past(tx_crc[7:0]))
    else $error("serial answer does not end in checksum");

endmodule

`default_nettype wire

// ===== mfs_master_model.sv
// mfs_master_model: request source and answer sink standing in for the remote master
`timescale 1ns/1ps
`default_nettype none

module mfs_master_model (
  input wire logic clk_in,
  input wire logic stall_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_end_out,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  output logic tx_ready_out
);
  logic [7:0] got[$];
  logic done = 1'b0;
  logic phase = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // quiet request bus at time zero
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_end_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  // one byte per cycle, then the frame-end pulse; caller starts just after an edge
  task automatic send(input logic [7:0] fr[$]);
    foreach (fr[i]) begin
      rx_data_out <= fr[i];
      rx_valid_out <= 1'b1;
      @(posedge clk_in);
    end
    rx_valid_out <= 1'b0;
    // released line must not keep showing the last byte
    rx_data_out <= ~fr[fr.size() - 1];
    rx_end_out <= 1'b1;
    @(posedge clk_in);
    rx_end_out <= 1'b0;
  endtask

  // forget the previous answer before a new request
  task automatic clear;
    got.delete();
    done = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // answer sink: stalls every other cycle when asked, so held bytes get exercised
  always @(posedge clk_in) begin
    phase <= ~phase;
    tx_ready_out <= !stall_in || phase;
    if (tx_valid_in && tx_ready_out) begin
      got.push_back(tx_data_in);
      if (tx_last_in)
        done <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// ===== mfs_tb_top.sv
// mfs_tb_top: table-driven and hand-written checks of the float register slave
`timescale 1ns/1ps
`default_nettype none

module mfs_tb_top;
  import mfs_pkg::*;
  typedef struct packed {
    logic tcp; logic big; logic [7:0] fc; logic [15:0] start; logic [15:0] cnt;
    logic [7:0] bc; logic [31:0] val; logic [7:0] exc;
  } mfs_row_type;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic tcp_mode_in = 1'b0;
  logic big_endian_in = 1'b0;
  logic param_fail_in = 1'b0;
  logic stall = 1'b0;
  logic [7:0] serial_id_in = 8'h11;
  logic [7:0] rx_data, tx_data_out, param_index_out;
  logic rx_valid, rx_end, rx_ready_out, tx_valid_out, tx_last_out, tx_ready, cal_update_out;
  logic [31:0] param_data_in;
  logic [1:0] exp_mode = 2'h0;
  mfs_cal_type cal_mode_out;
  int fails = 0;
  int n_compared = 0;
  int updates = 0;
  int exp_upd = 0;
  logic [7:0] req[$];
  logic [7:0] exp_q[$];
  mfs_row_type rows[18];

  ////////////////////////////////////////////////////////////////////////////////
  always #2 clk_in = ~clk_in;

  // parameter source: every byte differs except at indexes 0x3c, 0xbd and 0xc3, so swapped or shifted indexes show up
  function automatic logic [31:0] pd(input logic [7:0] i);
    return {i, ~i, 8'h3c, i ^ 8'h81};
  endfunction
  assign param_data_in = pd(param_index_out);

  always @(posedge clk_in)
    if (cal_update_out === 1'b1)
      updates++;

  mfs_slave uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .tcp_mode_in(tcp_mode_in), .serial_id_in(serial_id_in),
    .big_endian_in(big_endian_in), .param_fail_in(param_fail_in), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_end_in(rx_end), .rx_ready_out(rx_ready_out), .param_index_out(param_index_out),
    .param_data_in(param_data_in), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
    .tx_last_out(tx_last_out), .tx_ready_in(tx_ready), .cal_mode_out(cal_mode_out),
    .cal_update_out(cal_update_out));
  mfs_master_model mst (.clk_in(clk_in), .stall_in(stall), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_end_out(rx_end), .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out), .tx_last_in(tx_last_out),
    .tx_ready_out(tx_ready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // reflected checksum, kept apart from the design's own helper
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic push_f(ref logic [7:0] q[$], input logic [31:0] v, input logic big);
    for (int i = 0; i < 4; i++)
      q.push_back(big ? v[8*i +: 8] : v[8*(3-i) +: 8]);
  endtask

  function automatic logic [1:0] mode_of(input logic [31:0] v);
    case (v)
      32'h3f800000: return 2'h1;
      32'h40000000: return 2'h2;
      32'h40400000: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  // one transaction: build request and expected answer, send, compare everything
  task automatic run(input mfs_row_type r, input logic [7:0] id, input logic [7:0] crc_x);
    logic [15:0] c;
    logic drop;
    drop = !r.tcp && (id != 8'h11 || crc_x != 8'h00);
    req.delete();
    exp_q.delete();
    tcp_mode_in <= r.tcp;
    big_endian_in <= r.big;
    if (!r.tcp)
      req.push_back(id);
    req.push_back(r.fc);
    req.push_back(r.start[15:8]);
    req.push_back(r.start[7:0]);
    req.push_back(r.cnt[15:8]);
    req.push_back(r.cnt[7:0]);
    if (r.fc == 8'h10) begin
      req.push_back(r.bc);
      push_f(req, r.val, r.big);
    end
    c = crc16(req);
    if (!r.tcp) begin
      req.push_back(c[15:8]);
      req.push_back(c[7:0] ^ crc_x);
    end
    if (!r.tcp)
      exp_q.push_back(8'h11);
    if (r.exc != 8'h00) begin
      exp_q.push_back(r.fc | 8'h80);
      exp_q.push_back(r.exc);
    end else if (r.fc == 8'h03) begin
      exp_q.push_back(8'h03);
      exp_q.push_back(r.cnt[15:8]);
      exp_q.push_back(r.cnt[7:0]);
      for (int i = 0; i < r.cnt / 2; i++)
        push_f(exp_q, pd(8'((r.start - 16'h0100) / 2 + i)), r.big);
    end else begin
      exp_q.delete();
      for (int i = 0; i < 6; i++)
        exp_q.push_back(req[i]);
      exp_mode = mode_of(r.val);
      exp_upd++;
    end
    c = crc16(exp_q);
    if (!r.tcp) begin
      exp_q.push_back(c[15:8]);
      exp_q.push_back(c[7:0]);
    end
    if (drop)
      exp_q.delete();
    mst.clear();
    mst.send(req);
    for (int k = 0; k < (drop ? 20 : 900) && mst.done !== 1'b1; k++)
      @(posedge clk_in);
    @(posedge clk_in);
    chk({7'h0, mst.done}, {7'h0, !drop});
    chk(8'(mst.got.size()), 8'(exp_q.size()));
    foreach (exp_q[i])
      chk(mst.got[i], exp_q[i]);
    chk({6'h0, cal_mode_out}, {6'h0, exp_mode});
    chk(8'(updates), 8'(exp_upd));
    chk({7'h0, rx_ready_out}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: far beyond the longest expected run
  initial begin
    repeat (40000) @(posedge clk_in);
    fails++;
    end_sim;
  end

  initial begin
    rows = '{
      '{1'b0, 1'b0, 8'h03, 16'h0100, 16'h0002, 8'h00, 32'h0, 8'h00},
      '{1'b1, 1'b1, 8'h03, 16'h0102, 16'h0004, 8'h00, 32'h0, 8'h00},
      '{1'b0, 1'b1, 8'h03, 16'h0100, 16'h007c, 8'h00, 32'h0, 8'h00},
      '{1'b0, 1'b0, 8'h03, 16'h017e, 16'h0002, 8'h00, 32'h0, 8'h00},
      '{1'b0, 1'b0, 8'h03, 16'h0100, 16'h0000, 8'h00, 32'h0, 8'h03},
      '{1'b1, 1'b0, 8'h03, 16'h0100, 16'h007e, 8'h00, 32'h0, 8'h03},
      '{1'b0, 1'b0, 8'h03, 16'h00fe, 16'h0002, 8'h00, 32'h0, 8'h02},
      '{1'b0, 1'b0, 8'h03, 16'h0101, 16'h0002, 8'h00, 32'h0, 8'h02},
      '{1'b0, 1'b0, 8'h03, 16'h017e, 16'h0004, 8'h00, 32'h0, 8'h02},
      '{1'b0, 1'b0, 8'h04, 16'h0100, 16'h0002, 8'h00, 32'h0, 8'h01},
      '{1'b0, 1'b1, 8'h10, 16'h01aa, 16'h0002, 8'h04, 32'h3f800000, 8'h00},
      '{1'b1, 1'b0, 8'h10, 16'h01aa, 16'h0002, 8'h04, 32'h40000000, 8'h00},
      '{1'b0, 1'b0, 8'h10, 16'h01aa, 16'h0002, 8'h04, 32'h40400000, 8'h00},
      '{1'b1, 1'b1, 8'h10, 16'h01aa, 16'h0002, 8'h04, 32'h00000000, 8'h00},
      '{1'b0, 1'b0, 8'h10, 16'h01ab, 16'h0002, 8'h04, 32'h40000000, 8'h02},
      '{1'b0, 1'b0, 8'h10, 16'h01aa, 16'h0002, 8'h04, 32'h3f000000, 8'h03},
      '{1'b0, 1'b1, 8'h10, 16'h01aa, 16'h0002, 8'h05, 32'h40000000, 8'h03},
      '{1'b1, 1'b0, 8'h10, 16'h01aa, 16'h0004, 8'h04, 32'h40000000, 8'h03}};
    repeat (20) @(posedge clk_in);
    chk({7'h0, rx_ready_out}, 8'h01);
    chk({7'h0, tx_valid_out}, 8'h00);
    chk({6'h0, cal_mode_out}, 8'h00);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    foreach (rows[i]) begin
      stall <= i[0];
      run(rows[i], 8'h11, 8'h00);
    end
    // awkward cases: failed parameter source, foreign address, corrupted checksum
    param_fail_in <= 1'b1;
    run('{1'b0, 1'b0, 8'h03, 16'h0100, 16'h0002, 8'h00, 32'h0, 8'h04}, 8'h11, 8'h00);
    param_fail_in <= 1'b0;
    run(rows[0], 8'h12, 8'h00);
    run(rows[3], 8'h11, 8'h01);
    // a mid-run reset must drop the span state back to measure
    run(rows[12], 8'h11, 8'h00);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({6'h0, cal_mode_out}, 8'h00);
    chk({7'h0, tx_valid_out}, 8'h00);
    rst_n_in <= 1'b1;
    exp_mode = 2'h0;
    @(posedge clk_in);
    run(rows[1], 8'h11, 8'h00);
    end_sim;
  end
endmodule

`default_nettype wire
